// file: hw/fci_pkg.sv
// shared constants and types for the flash command host controller
package fci_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 8;
  localparam int TIMER_W = 21;

  // ==========================================================================
  // command and data codes
  localparam logic [7:0] CMD_SET_READ  = 8'h00;
  localparam logic [7:0] CMD_SIG       = 8'h90;
  localparam logic [7:0] CMD_ERASE     = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'ha0;
  localparam logic [7:0] CMD_PROG      = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY  = 8'hc0;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  localparam logic [7:0] PREPROG_BYTE  = 8'h00;
  localparam logic [16:0] LAST_ADDR    = 17'h1ffff;

  // ==========================================================================
  // loop limits
  localparam int PROG_TRIES  = 25;
  localparam int ERASE_TRIES = 1000;

  // ==========================================================================
  // times in ns, cycles rounded up at the clock period
  localparam int CLK_NS          = 8;
  localparam int T_VPP_SETUP_NS  = 100;
  localparam int T_WE_LOW_NS     = 40;
  localparam int T_WE_HIGH_NS    = 20;
  localparam int T_ACCESS_NS     = 120;
  localparam int T_PROG_NS       = 10000;
  localparam int T_RECOV_NS      = 6000;
  localparam int T_ERASE_NS      = 9500000;
  localparam int VPP_SETUP_CYC   = (T_VPP_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC      = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC     = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC      = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC        = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC       = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC       = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // user operations
  typedef enum logic [2:0] {
    OP_READ  = 3'b000,
    OP_SIG   = 3'b001,
    OP_PROG  = 3'b010,
    OP_ERASE = 3'b011,
    OP_RESET = 3'b100
  } fci_op_t;

endpackage : fci_pkg

// file: hw/fci_host.sv
// host controller that runs read, signature, program, erase and reset on the flash pins
`timescale 1ns/100ps
// What this block does
// R01 - commands go out as one or two writes
// R02 - supply raised and settled before any write
// R03 - command byte valid at write strobe rise
// R04 - address and data held through write strobe
// R05 - read with select and enable low
// R07 - data bus released when not writing
// R06 - set-read first when supply high
// R08 - high-voltage signature left to device side
// R09 - erase verify writes A0H then reads
// R10 - program writes 40H then address/data
// R11 - device times its own pulses
// R12 - wait pulse plus recovery before verify
// R13 - at most 25 program tries per byte
// R14 - all bytes programmed 00H before erase
// R15 - 00H write returns to array read
// R16 - 90H then read address 0 or 1
// R17 - erase needs two 20H writes
// R18 - two FFH writes abort and reset
// R19 - C0H verify reads the held address
// R20 - device starts in array read mode
module fci_host #(
  parameter int ERASE_PULSE_CYC = fci_pkg::ERASE_CYC,
  parameter logic [16:0] SWEEP_LAST = fci_pkg::LAST_ADDR
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  input  wire fci_pkg::fci_op_t     cmd_op,
  input  wire logic [16:0]          cmd_addr,
  input  wire logic [7:0]           cmd_data,
  output logic                      cmd_ready,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  output logic                      rsp_fail,
  output logic                      flash_ce_n,
  output logic                      flash_oe_n,
  output logic                      flash_we_n,
  output logic [16:0]               flash_addr,
  output logic [7:0]                flash_dq_o,
  output logic                      flash_dq_oe,
  input  wire logic [7:0]           flash_dq_i,
  output logic                      program_supply_high
);

  localparam int TW = fci_pkg::TIMER_W;

  typedef enum logic [4:0] {
    S_IDLE    = 5'b00000, S_SUPPLY  = 5'b00001, S_SETRD   = 5'b00010,
    S_ARR_RD  = 5'b00011, S_SIG_WR  = 5'b00100, S_PROG1   = 5'b00101,
    S_PROG2   = 5'b00110, S_PWAIT   = 5'b00111, S_PVFY_WR = 5'b01000,
    S_PRECOV  = 5'b01001, S_PVFY_RD = 5'b01010, S_ERS1    = 5'b01011,
    S_ERS2    = 5'b01100, S_EWAIT   = 5'b01101, S_EVFY_WR = 5'b01110,
    S_ERECOV  = 5'b01111, S_EVFY_RD = 5'b10000, S_RST1    = 5'b10001,
    S_RST2    = 5'b10010, S_DONE    = 5'b10011
  } fci_seq_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b10, E_HIGH = 2'b11
  } fci_eng_t;

  fci_seq_t          seq_r, seq_nxt;
  fci_eng_t          eng_r;
  fci_pkg::fci_op_t  op_r;
  logic [16:0]       op_addr_r, sweep_r, tgt_addr, req_addr;
  logic [7:0]        op_data_r, tgt_data, req_data, rd_data_r;
  logic              req_wr, bus_done_r, read_mode_r, fail_r;
  logic [3:0]        eng_cnt_r;
  logic [TW-1:0]     timer_r;
  logic [4:0]        try_cnt_r;
  logic [9:0]        erase_cnt_r;

  // states that run one bus cycle
  function automatic logic is_bus(input fci_seq_t s);
    is_bus = !(s inside {S_IDLE, S_SUPPLY, S_PWAIT, S_PRECOV, S_EWAIT, S_ERECOV, S_DONE});
  endfunction : is_bus

  // ==========================================================================
  // bus request per state
  assign tgt_addr = (op_r == fci_pkg::OP_ERASE) ? sweep_r : op_addr_r;
  assign tgt_data = (op_r == fci_pkg::OP_ERASE) ? fci_pkg::PREPROG_BYTE : op_data_r;

  always_comb begin
    req_wr   = 1'b1;
    req_addr = 17'h00000;
    req_data = fci_pkg::CMD_SET_READ;
    case (seq_r)
      S_SETRD:   req_data = fci_pkg::CMD_SET_READ;                  // R15
      S_SIG_WR:  req_data = fci_pkg::CMD_SIG;                       // R16
      S_PROG1:   req_data = fci_pkg::CMD_PROG;                      // R10
      S_PROG2: begin                                                // R10
        req_addr = tgt_addr;
        req_data = tgt_data;
      end
      S_PVFY_WR: req_data = fci_pkg::CMD_PROG_VFY;                  // R19
      S_ERS1, S_ERS2: req_data = fci_pkg::CMD_ERASE;                // R17
      S_EVFY_WR: begin                                              // R09
        req_addr = sweep_r;
        req_data = fci_pkg::CMD_ERASE_VFY;
      end
      S_RST1, S_RST2: req_data = fci_pkg::CMD_RESET;                // R18
      S_ARR_RD: begin
        req_wr   = 1'b0;
        req_addr = (op_r == fci_pkg::OP_SIG) ? {16'h0000, op_addr_r[0]} : op_addr_r; // R16
      end
      S_PVFY_RD, S_EVFY_RD: begin
        req_wr   = 1'b0;
        req_addr = tgt_addr;
      end
      default: req_wr = 1'b1;
    endcase
  end

  // ==========================================================================
  // sequencer next state; device times its pulses, we only wait them out
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      S_IDLE: if (cmd_valid && cmd_ready) begin
        if (cmd_op == fci_pkg::OP_READ)
          seq_nxt = (program_supply_high && !read_mode_r) ? S_SETRD : S_ARR_RD; // R06
        else if (!program_supply_high)
          seq_nxt = S_SUPPLY;                                       // R02
        else if (cmd_op == fci_pkg::OP_SIG)
          seq_nxt = S_SIG_WR;
        else if (cmd_op == fci_pkg::OP_RESET)
          seq_nxt = S_RST1;
        else
          seq_nxt = S_PROG1;                                        // R14
      end
      S_SUPPLY: if (timer_r == '0) begin
        case (op_r)
          fci_pkg::OP_SIG:   seq_nxt = S_SIG_WR;
          fci_pkg::OP_RESET: seq_nxt = S_RST1;
          default:           seq_nxt = S_PROG1;
        endcase
      end
      S_SETRD:   if (bus_done_r) seq_nxt = S_ARR_RD;
      S_SIG_WR:  if (bus_done_r) seq_nxt = S_ARR_RD;
      S_ARR_RD:  if (bus_done_r) seq_nxt = S_DONE;
      S_PROG1:   if (bus_done_r) seq_nxt = S_PROG2;
      S_PROG2:   if (bus_done_r) seq_nxt = S_PWAIT;
      S_PWAIT:   if (timer_r == '0) seq_nxt = S_PVFY_WR;            // R11
      S_PVFY_WR: if (bus_done_r) seq_nxt = S_PRECOV;
      S_PRECOV:  if (timer_r == '0) seq_nxt = S_PVFY_RD;            // R12
      S_PVFY_RD: if (bus_done_r) begin
        if (rd_data_r == tgt_data) begin
          if (op_r != fci_pkg::OP_ERASE)   seq_nxt = S_DONE;
          else if (sweep_r == SWEEP_LAST)  seq_nxt = S_ERS1;        // R14
          else                             seq_nxt = S_PROG1;
        end else begin
          seq_nxt = (try_cnt_r == 5'(fci_pkg::PROG_TRIES - 1)) ? S_DONE : S_PROG1; // R13
        end
      end
      S_ERS1:    if (bus_done_r) seq_nxt = S_ERS2;
      S_ERS2:    if (bus_done_r) seq_nxt = S_EWAIT;
      S_EWAIT:   if (timer_r == '0) seq_nxt = S_EVFY_WR;            // R11
      S_EVFY_WR: if (bus_done_r) seq_nxt = S_ERECOV;
      S_ERECOV:  if (timer_r == '0) seq_nxt = S_EVFY_RD;
      S_EVFY_RD: if (bus_done_r) begin
        if (rd_data_r == fci_pkg::ERASED_BYTE)
          seq_nxt = (sweep_r == SWEEP_LAST) ? S_DONE : S_EVFY_WR;
        else
          seq_nxt = (erase_cnt_r == 10'(fci_pkg::ERASE_TRIES - 1)) ? S_DONE : S_ERS1;
      end
      S_RST1:    if (bus_done_r) seq_nxt = S_RST2;
      S_RST2:    if (bus_done_r) seq_nxt = S_DONE;
      S_DONE:    seq_nxt = S_IDLE;
      default:   seq_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) seq_r <= S_IDLE;
    else        seq_r <= seq_nxt;
  end

  // ==========================================================================
  // wait timer, loaded on entry to a waiting state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= '0;
    end else if (seq_nxt != seq_r) begin
      case (seq_nxt)
        S_SUPPLY:           timer_r <= TW'(fci_pkg::VPP_SETUP_CYC);
        S_PWAIT:            timer_r <= TW'(fci_pkg::PROG_CYC);
        S_PRECOV, S_ERECOV: timer_r <= TW'(fci_pkg::RECOV_CYC);
        S_EWAIT:            timer_r <= TW'(ERASE_PULSE_CYC);
        default:            timer_r <= '0;
      endcase
    end else if (timer_r != '0) begin
      timer_r <= timer_r - 1'b1;
    end
  end

  // ==========================================================================
  // operation capture, loop counters and result flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r        <= fci_pkg::OP_READ;
      op_addr_r   <= 17'h00000;
      op_data_r   <= 8'h00;
      sweep_r     <= 17'h00000;
      try_cnt_r   <= 5'h00;
      erase_cnt_r <= 10'h000;
      fail_r      <= 1'b0;
    end else if (seq_r == S_IDLE && cmd_valid && cmd_ready) begin
      op_r        <= cmd_op;
      op_addr_r   <= cmd_addr;
      op_data_r   <= cmd_data;
      sweep_r     <= 17'h00000;
      try_cnt_r   <= 5'h00;
      erase_cnt_r <= 10'h000;
      fail_r      <= 1'b0;
    end else if (bus_done_r && seq_r == S_PVFY_RD) begin
      if (rd_data_r == tgt_data) begin
        try_cnt_r <= 5'h00;                                         // fresh budget per byte
        sweep_r   <= (sweep_r == SWEEP_LAST) ? 17'h00000 : sweep_r + 17'h00001;
      end else if (try_cnt_r == 5'(fci_pkg::PROG_TRIES - 1)) begin
        fail_r <= 1'b1;                                             // R13
      end else begin
        try_cnt_r <= try_cnt_r + 5'h01;
      end
    end else if (bus_done_r && seq_r == S_EVFY_RD) begin
      if (rd_data_r == fci_pkg::ERASED_BYTE)
        sweep_r <= sweep_r + 17'h00001;                             // resume where it failed
      else if (erase_cnt_r == 10'(fci_pkg::ERASE_TRIES - 1))
        fail_r <= 1'b1;
      else
        erase_cnt_r <= erase_cnt_r + 10'h001;
    end
  end

  // ==========================================================================
  // what mode the device is left in; it powers up reading the array
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      read_mode_r <= 1'b1;                                          // R20
    else if (bus_done_r && req_wr && seq_r != S_PROG2)
      read_mode_r <= (req_data == fci_pkg::CMD_SET_READ) || (seq_r == S_RST2); // R15
  end

  // ==========================================================================
  // supply stays high once raised so back-to-back jobs skip the setup wait
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)                  program_supply_high <= 1'b0;
    else if (seq_nxt == S_SUPPLY) program_supply_high <= 1'b1;      // R02
  end

  // ==========================================================================
  // bus cycle engine: one write or read per request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_r <= E_IDLE; eng_cnt_r <= 4'h0; bus_done_r <= 1'b0; rd_data_r <= 8'h00;
      flash_ce_n <= 1'b1; flash_oe_n <= 1'b1; flash_we_n <= 1'b1;
      flash_addr <= 17'h00000; flash_dq_o <= 8'h00; flash_dq_oe <= 1'b0;
    end else begin
      bus_done_r <= 1'b0;
      case (eng_r)
        E_IDLE: if (is_bus(seq_r) && !bus_done_r) begin             // R01
          flash_ce_n <= 1'b0;
          flash_addr <= req_addr;                                   // R04
          flash_dq_o <= req_data;
          eng_r      <= E_SETUP;
        end
        E_SETUP: begin
          flash_dq_oe <= req_wr;
          flash_we_n  <= !req_wr;
          flash_oe_n  <= req_wr;                                    // R05
          eng_cnt_r   <= req_wr ? 4'(fci_pkg::WE_LOW_CYC - 1) : 4'(fci_pkg::ACCESS_CYC - 1);
          eng_r       <= E_STROBE;
        end
        E_STROBE: if (eng_cnt_r == 4'h0) begin
          if (!flash_oe_n) rd_data_r <= flash_dq_i;
          flash_we_n <= 1'b1;                                       // R03
          flash_oe_n <= 1'b1;
          eng_cnt_r  <= 4'(fci_pkg::WE_HIGH_CYC - 1);
          eng_r      <= E_HIGH;
        end else begin
          eng_cnt_r <= eng_cnt_r - 4'h1;
        end
        E_HIGH: if (eng_cnt_r == 4'h0) begin
          flash_dq_oe <= 1'b0;                                      // R07
          flash_ce_n  <= 1'b1;
          bus_done_r  <= 1'b1;
          eng_r       <= E_IDLE;
        end else begin
          eng_cnt_r <= eng_cnt_r - 4'h1;
        end
        default: eng_r <= E_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // user response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b1; rsp_valid <= 1'b0; rsp_data <= 8'h00; rsp_fail <= 1'b0;
    end else begin
      cmd_ready <= (seq_nxt == S_IDLE);
      rsp_valid <= (seq_r == S_DONE);
      if (seq_r == S_DONE) begin
        rsp_data <= rd_data_r;
        rsp_fail <= fail_r;
      end
    end
  end

  // ==========================================================================
  // checker helpers: last written byte and time since the program write
  logic [7:0]  last_wr_r;
  logic [11:0] prog_gap_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_wr_r <= 8'h00; prog_gap_r <= 12'hfff;
    end else begin
      if ($rose(flash_we_n)) last_wr_r <= flash_dq_o;
      if (bus_done_r && seq_r == S_PROG2) prog_gap_r <= 12'h000;
      else if (prog_gap_r != 12'hfff)     prog_gap_r <= prog_gap_r + 12'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence we_low_s;  (!flash_we_n) [*5]; endsequence
  sequence we_high_s; (flash_we_n && flash_dq_oe && !flash_ce_n) [*3]; endsequence

  AST_SUPPLY_BEFORE_WRITE: assert property ($fell(flash_we_n) |->   // R02
    program_supply_high && $past(program_supply_high, 13)) else $error("write without supply");
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> we_low_s ##1 we_high_s) // R03
    else $error("write strobe shape wrong");
  AST_ADDR_HELD: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr)) // R04
    else $error("address moved in cycle");
  AST_NO_CONTENTION: assert property (!flash_oe_n |->             // R07
    !flash_dq_oe && flash_we_n && !flash_ce_n) else $error("read while driving");
  AST_SET_READ_FIRST: assert property ($fell(flash_oe_n) && op_r == fci_pkg::OP_READ && // R06
    program_supply_high |-> read_mode_r) else $error("array read before set-read");
  AST_PROG_PAIR: assert property ($fell(flash_we_n) && seq_r == S_PROG2 |-> // R10
    last_wr_r == fci_pkg::CMD_PROG && flash_addr == tgt_addr && flash_dq_o == tgt_data)
    else $error("program write not after 40h");
  AST_ERASE_PAIR: assert property ($fell(flash_we_n) && seq_r == S_ERS2 |-> // R17
    last_wr_r == fci_pkg::CMD_ERASE) else $error("single erase write");
  AST_EVFY_ORDER: assert property ($fell(flash_oe_n) && seq_r == S_EVFY_RD |-> // R09
    last_wr_r == fci_pkg::CMD_ERASE_VFY && flash_addr == sweep_r) else $error("bad erase verify");
  AST_PROG_GAP: assert property ($fell(flash_oe_n) && seq_r == S_PVFY_RD |-> // R12
    prog_gap_r >= 12'(fci_pkg::PROG_CYC + fci_pkg::RECOV_CYC)) else $error("verify too early");
  AST_TRIES: assert property (try_cnt_r < 5'(fci_pkg::PROG_TRIES)) // R13
    else $error("too many program tries");
  AST_PREPROG: assert property (seq_r == S_ERS1 && $past(seq_r) == S_PVFY_RD |-> // R14
    $past(sweep_r) == SWEEP_LAST && $past(rd_data_r) == fci_pkg::PREPROG_BYTE)
    else $error("erase before preprogram");
  AST_SIG_ADDR: assert property ($fell(flash_oe_n) && op_r == fci_pkg::OP_SIG |-> // R16
    last_wr_r == fci_pkg::CMD_SIG && flash_addr[16:1] == 16'h0000) else $error("bad signature read");

endmodule : fci_host

// file: testbench/fci_flash_model.sv
// behavioural model of the parallel flash device on the far side of the host pins
`timescale 1ns/100ps
module fci_flash_model #(
  parameter logic [7:0]  MFG_CODE   = 8'h5e,   // arbitrary value
  parameter logic [7:0]  DEV_CODE   = 8'ha7,   // arbitrary value
  parameter logic [16:0] SWEEP_LAST = 17'h00003
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  host_dq,
  input  wire logic        host_dq_oe,
  input  wire logic        supply_high,
  input  wire logic        fail_prog,
  output logic [7:0]       dq_in,
  output int               viol_cnt,
  output int               prog_cnt
);
  // ==========================================================================
  // state
  typedef enum logic [3:0] {
    MD_READ, MD_SIG, MD_ER1, MD_ERASED, MD_EVFY, MD_PROG1, MD_PROGGED, MD_PVFY, MD_FF1
  } fci_mode_t;
  fci_mode_t   mode_r;
  logic [7:0]  mem [0:131071];
  logic [16:0] lat_addr_r;
  logic [16:0] prog_addr_r;
  logic [16:0] vfy_addr_r;
  logic [7:0]  last_r;
  logic [7:0]  rd;
  logic        drive;
  realtime     t_supply;
  realtime     t_write;
  realtime     t_prog;

  // power-up contents and mode
  initial begin
    mode_r = MD_READ;
    last_r = 8'h00;
    viol_cnt = 0;
    prog_cnt = 0;
    t_supply = 0.0;
    t_write = 0.0;
    t_prog = 0.0;
    for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5a;
  end

  // ==========================================================================
  // command register
  // address is latched at strobe fall so the host may move it afterwards
  always @(negedge we_n) if (!ce_n) lat_addr_r = addr;
  always @(posedge we_n) begin
    if (!ce_n && supply_high) begin
      t_write = $realtime;
      if (mode_r == MD_PROG1) begin
        prog_cnt++;
        prog_addr_r = lat_addr_r;
        mem[lat_addr_r] = fail_prog ? (host_dq ^ 8'h01) : host_dq;
        t_prog = $realtime;
        mode_r = MD_PROGGED;
      end else begin
        case (host_dq)
          fci_pkg::CMD_SET_READ: mode_r = MD_READ;
          fci_pkg::CMD_SIG:      mode_r = MD_SIG;
          fci_pkg::CMD_ERASE: if (mode_r == MD_ER1) begin
            for (int i = 0; i <= int'(SWEEP_LAST); i++) if (mem[i] !== 8'h00) viol_cnt++;
            for (int i = 0; i < 131072; i++) mem[i] = fci_pkg::ERASED_BYTE;
            mode_r = MD_ERASED;
          end else mode_r = MD_ER1;
          fci_pkg::CMD_ERASE_VFY: begin
            vfy_addr_r = lat_addr_r;
            mode_r = MD_EVFY;
          end
          fci_pkg::CMD_PROG:     mode_r = MD_PROG1;
          fci_pkg::CMD_PROG_VFY: mode_r = MD_PVFY;
          fci_pkg::CMD_RESET:    mode_r = (mode_r == MD_FF1) ? MD_READ : MD_FF1;
          default:               mode_r = MD_READ;
        endcase
      end
    end
  end

  // ==========================================================================
  // read path; with supply high, a mode other than read, signature or verify gives wrong data on purpose
  always @* begin
    drive = !ce_n && !oe_n && we_n;
    if (!supply_high || mode_r == MD_READ) rd = mem[addr];
    else if (mode_r == MD_SIG) rd = addr[0] ? DEV_CODE : MFG_CODE;
    else if (mode_r == MD_EVFY) rd = mem[vfy_addr_r];
    else if (mode_r == MD_PVFY) rd = mem[prog_addr_r];
    else rd = ~mem[addr];
  end
  // no pull-up on the bus: a released bus shows the inverse of the last byte
  always @(posedge oe_n) last_r = rd;
  assign dq_in = host_dq_oe ? host_dq : (drive ? rd : ~last_r);

  // ==========================================================================
  // host timing and contention checks
  always @(posedge supply_high) t_supply = $realtime;
  always @(negedge ce_n) if (supply_high && $realtime - t_supply < 100.0) viol_cnt++;
  always @(posedge host_dq_oe) if (!oe_n && !ce_n) viol_cnt++;
  always @(negedge oe_n) begin
    if (host_dq_oe) viol_cnt++;
    if ((mode_r == MD_PVFY || mode_r == MD_EVFY) && $realtime - t_write < 6000.0) viol_cnt++;
    if (mode_r == MD_PVFY && $realtime - t_prog < 16000.0) viol_cnt++;
  end
endmodule : fci_flash_model

// file: testbench/fci_host_tb.sv
// self-checking testbench of the flash host controller against the device model
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t ns %s", $time, m); end end
module fci_host_tb;
  // ==========================================================================
  // signals
  typedef struct packed {
    fci_pkg::fci_op_t op;
    logic [16:0]      a;
    logic [7:0]       d;
    logic [7:0]       exp;
    logic             chk;
    int               lat;
  } fci_row_t;
  logic ref_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_fail, fail_prog;
  logic ce_n, oe_n, we_n, dq_oe, supply;
  fci_pkg::fci_op_t cmd_op;
  logic [16:0] cmd_addr, f_addr;
  logic [7:0]  cmd_data, rsp_data, dq_o, dq_i, rd;
  logic        fl;
  int          viol_cnt, prog_cnt, lat, p0, error_cnt, checks;
  fci_row_t    rows [12];

  fci_host #(.ERASE_PULSE_CYC(20), .SWEEP_LAST(17'h00003)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_fail(rsp_fail), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_dq_i(dq_i), .program_supply_high(supply));
  fci_flash_model #(.SWEEP_LAST(17'h00003)) u_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .host_dq(dq_o),
    .host_dq_oe(dq_oe), .supply_high(supply), .fail_prog(fail_prog), .dq_in(dq_i),
    .viol_cnt(viol_cnt), .prog_cnt(prog_cnt));

  function automatic logic [7:0] init_byte(input logic [16:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : init_byte

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // one request, held until taken, then wait for the response pulse
  task automatic run_op(input fci_pkg::fci_op_t op, input logic [16:0] a, input logic [7:0] d);
    int k;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK(cmd_ready, 1'b1, "request never taken")
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 90000) begin
      @(negedge ref_clk);
      lat++;
    end
    `CHK(rsp_valid, 1'b1, "no response before limit")
    rd = rsp_data;
    fl = rsp_fail;
  endtask : run_op

  // ==========================================================================
  // clock and watchdog; the longest case is 25 program tries of about 2060 cycles
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t ns watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = fci_pkg::OP_READ;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    fail_prog = 1'b0;
    rows = '{
      '{fci_pkg::OP_READ, 17'h00000, 8'h00, init_byte(17'h00000), 1'b1, 22},
      '{fci_pkg::OP_READ, 17'h1ffff, 8'h00, init_byte(17'h1ffff), 1'b1, 0},
      '{fci_pkg::OP_READ, 17'h00001, 8'h00, init_byte(17'h00001), 1'b1, 0},
      '{fci_pkg::OP_SIG, 17'h00000, 8'h00, 8'h5e, 1'b1, 0},
      '{fci_pkg::OP_SIG, 17'h00001, 8'h00, 8'ha7, 1'b1, 0},
      '{fci_pkg::OP_READ, 17'h00005, 8'h00, init_byte(17'h00005), 1'b1, 0},
      '{fci_pkg::OP_PROG, 17'h00002, 8'h3c, 8'h3c, 1'b1, 0},
      '{fci_pkg::OP_READ, 17'h00002, 8'h00, 8'h3c, 1'b1, 0},
      '{fci_pkg::OP_ERASE, 17'h00000, 8'h00, 8'hff, 1'b1, 0},
      '{fci_pkg::OP_READ, 17'h00003, 8'h00, 8'hff, 1'b1, 0},
      '{fci_pkg::OP_RESET, 17'h00000, 8'h00, 8'h00, 1'b0, 0},
      '{fci_pkg::OP_READ, 17'h00000, 8'h00, 8'hff, 1'b1, 0}
    };
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    // ordinary operations from the table
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].a, rows[i].d);
      `CHK(fl, 1'b0, "unexpected fail flag")
      if (rows[i].chk) `CHK(rd, rows[i].exp, "response byte")
      if (rows[i].lat != 0) `CHK(lat, rows[i].lat, "read latency")
      $display("row %0d done", i);
    end
    // a byte that never verifies is given up after the retry limit
    fail_prog = 1'b1;
    p0 = prog_cnt;
    run_op(fci_pkg::OP_PROG, 17'h00007, 8'h55);
    fail_prog = 1'b0;
    `CHK(fl, 1'b1, "failed program not flagged")
    `CHK(prog_cnt - p0, fci_pkg::PROG_TRIES, "program try count")
    `CHK(viol_cnt, 0, "device timing or contention violation")
    $display("retry test done");
    // reset in the middle of a program
    cmd_op = fci_pkg::OP_PROG;
    cmd_addr = 17'h0000b;
    cmd_data = 8'h11;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    repeat (30) @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    `CHK({cmd_ready, rsp_valid, ce_n, oe_n, we_n, dq_oe}, 6'b101110, "reset strobes")
    `CHK(supply, 1'b0, "supply not low in reset")
    rst_n = 1'b1;
    run_op(fci_pkg::OP_READ, 17'h00009, 8'h00);
    `CHK(rd, 8'hff, "read after mid-run reset")
    `CHK(viol_cnt, 0, "device violation after reset")
    $display("reset test done");
    end_of_test();
  end
endmodule : fci_host_tb
